// ===== spd_pkg.sv
// Constants and types for the serial transceiver powerdown control
`default_nettype none

package spd_pkg;

    // Clock
    localparam int unsigned CLK_PERIOD_NS = 10;

    // Inactivity timer: 30 s without an edge
    localparam longint unsigned IDLE_TIME_S = 30;
    localparam longint unsigned IDLE_CYC_L =
        IDLE_TIME_S * 64'd1_000_000_000 / CLK_PERIOD_NS;
    localparam int IDLE_W = 32;
    localparam logic [IDLE_W-1:0] IDLE_CYC_DEF = IDLE_W'(IDLE_CYC_L);

    // Invalid level must persist longer than 30 us
    localparam int unsigned INVALID_TIME_NS = 30000;
    localparam int INV_W = 12;
    localparam logic [INV_W-1:0] INVALID_CYC =
        INV_W'((INVALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Valid level reported after 1 us
    localparam int unsigned VALID_TIME_NS = 1000;
    localparam int VAL_W = 8;
    localparam logic [VAL_W-1:0] VALID_CYC =
        VAL_W'((VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Transmission resumes at most 100 us after leaving powerdown
    localparam int unsigned RESUME_TIME_NS = 100000;
    localparam int RES_W = 16;
    localparam logic [RES_W-1:0] RESUME_CYC_DEF =
        RES_W'(RESUME_TIME_NS / CLK_PERIOD_NS);

    // Channel counts and pin vector layout
    localparam int N_TX = 3;
    localparam int N_RX = 5;
    localparam int MON_RX_IDX = 0;
    localparam int PIN_W = 2 + N_TX + 2 * N_RX + 1;
    localparam int HOLD_IDX = 0;
    localparam int SD_IDX = 1;
    localparam int TX_LO = 2;
    localparam int RX_LO = TX_LO + N_TX;
    localparam int LVL_LO = RX_LO + N_RX;
    localparam int NEG_IDX = LVL_LO + N_RX;
    localparam logic [PIN_W-1:0] PIN_RESET = '0;

    // Register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IDLE = 8'h08;
    localparam int CTRL_FIVE_RX_BIT = 0;
    localparam logic CTRL_FIVE_RX_RESET = 1'b1;
    localparam int STAT_ON_BIT = 0;
    localparam int STAT_AUTO_BIT = 1;
    localparam int STAT_MAN_BIT = 2;
    localparam int STAT_EXP_BIT = 3;
    localparam int STAT_LVL_BIT = 4;
    localparam int STAT_RDY_BIT = 5;
    localparam int STAT_TXEN_BIT = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SPD_ON = 3'h1,
        SPD_AUTO_OFF = 3'h2,
        SPD_MAN_OFF = 3'h4
    } spd_state_t;

endpackage

`default_nettype wire

// ===== spd_level_detect.sv
// Valid line level detector with persistence timers
`default_nettype none
`timescale 1ns/1ps

module spd_level_detect
    import spd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic any_valid,
    output var logic level_ok
);

    logic [INV_W-1:0] inv_cnt;
    logic [VAL_W-1:0] val_cnt;
    logic inv_done;
    logic val_done;

    assign inv_done = (inv_cnt == INVALID_CYC);
    assign val_done = (val_cnt == VALID_CYC - VAL_W'(1));

    // Runs in every power state; never touches power control
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inv_cnt <= '0;
            val_cnt <= '0;
            level_ok <= 1'b0;
        end else if (clk_en) begin
            if (any_valid) begin
                inv_cnt <= '0;
                if (val_done) begin
                    level_ok <= 1'b1;
                end else begin
                    val_cnt <= val_cnt + VAL_W'(1);
                end
            end else begin
                val_cnt <= '0;
                if (inv_done) begin
                    level_ok <= 1'b0;
                end else begin
                    inv_cnt <= inv_cnt + INV_W'(1);
                end
            end
        end
    end

endmodule // spd_level_detect

`default_nettype wire

// ===== spd_powerdown_ctrl.sv
// Powerdown control for a multi-channel serial line transceiver
`default_nettype none
`timescale 1ns/1ps

module spd_powerdown_ctrl
    import spd_pkg::*;
#(
    parameter logic [IDLE_W-1:0] IDLE_CYC = IDLE_CYC_DEF,
    parameter logic [RES_W-1:0] RESUME_CYC = RESUME_CYC_DEF
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Control pins from the host power logic
    input wire logic hold_awake_in,
    input wire logic shutdown_req_n,
    // Line side logic levels
    input wire logic [N_TX-1:0] tx_data_in,
    input wire logic [N_RX-1:0] rx_data_in,
    input wire logic [N_RX-1:0] rx_level_valid,
    input wire logic neg_supply_ok,
    // Power and driver controls
    output var logic charge_pump_en,
    output var logic [N_TX-1:0] tx_out,
    output var logic [N_TX-1:0] tx_oe_n,
    output var logic [N_RX-1:0] rx_data_out,
    output var logic [N_RX-1:0] rx_oe_n,
    output var logic wake_monitor_out,
    output logic level_ok_out,
    output var logic ready_out,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output var logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp
);

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        reg_mapped = (a == REG_CTRL) || (a == REG_STATUS) ||
            (a == REG_IDLE);
    endfunction

    // ---------------- Pin synchronisers ----------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;
    logic [PIN_W-1:0] pin_clean;
    logic [PIN_W-1:0] pin_prev;
    logic [PIN_W-1:0] next_clean;

    assign pin_raw = {neg_supply_ok, rx_level_valid, rx_data_in,
        tx_data_in, shutdown_req_n, hold_awake_in};
    // A change counts once second and third stages agree
    assign next_clean = (pin_s2 & pin_s3) | (pin_clean & (pin_s2 ^ pin_s3));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= PIN_RESET;
            pin_s2 <= PIN_RESET;
            pin_s3 <= PIN_RESET;
            pin_clean <= PIN_RESET;
            pin_prev <= PIN_RESET;
        end else if (clk_en) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_clean <= next_clean;
            pin_prev <= pin_clean;
        end
    end

    logic hold;
    logic sd_n;
    logic hold_rise;
    logic supply_ok;
    logic [N_TX-1:0] tx_clean;
    logic [N_RX-1:0] rx_clean;
    logic [N_RX-1:0] lvl_clean;
    logic [N_TX+N_RX-1:0] edge_vec;
    logic any_edge;
    logic any_valid;

    assign hold = pin_clean[HOLD_IDX];
    assign sd_n = pin_clean[SD_IDX];
    assign hold_rise = hold & ~pin_prev[HOLD_IDX];
    assign supply_ok = pin_clean[NEG_IDX];
    assign tx_clean = pin_clean[TX_LO +: N_TX];
    assign rx_clean = pin_clean[RX_LO +: N_RX];
    assign lvl_clean = pin_clean[LVL_LO +: N_RX];
    assign edge_vec = pin_clean[TX_LO +: N_TX+N_RX] ^
        pin_prev[TX_LO +: N_TX+N_RX];
    assign any_edge = |edge_vec;
    assign any_valid = |lvl_clean;

    // ---------------- Inactivity timer ----------------
    logic [IDLE_W-1:0] idle_cnt;
    logic [IDLE_W-1:0] next_idle;
    logic expired;
    logic next_expired;
    logic auto_en;
    logic idle_done;

    assign auto_en = ~hold & sd_n;
    assign idle_done = (idle_cnt == IDLE_CYC - IDLE_W'(1));

    // Edges and hold high keep the count at zero
    assign next_idle = (!auto_en || any_edge || expired) ? '0 :
        idle_cnt + IDLE_W'(1);

    // Manual entry sets; wake events clear; count end sets
    assign next_expired = !sd_n ? 1'b1 :
        (any_edge || hold_rise) ? 1'b0 :
        (auto_en && idle_done) ? 1'b1 :
        expired;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            idle_cnt <= '0;
            expired <= 1'b1;
        end else if (clk_en) begin
            idle_cnt <= next_idle;
            expired <= next_expired;
        end
    end

    // ---------------- Power state ----------------
    spd_state_t state;
    spd_state_t next_state;
    logic next_on;

    always_comb begin
        next_state = state;
        if (!sd_n) begin
            next_state = SPD_MAN_OFF;
        end else if (hold || !expired) begin
            next_state = SPD_ON;
        end else begin
            next_state = SPD_AUTO_OFF;
        end
    end

    assign next_on = (next_state == SPD_ON);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= SPD_MAN_OFF;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ---------------- Wake timing ----------------
    logic [RES_W-1:0] wake_cnt;
    logic resume_done;
    logic next_tx_en;

    assign resume_done = (wake_cnt == RESUME_CYC);
    // Drivers start on supply ok, or at the latest when time runs out
    assign next_tx_en = next_on && (supply_ok || resume_done);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_cnt <= '0;
        end else if (clk_en) begin
            if (state != SPD_ON) begin
                wake_cnt <= '0;
            end else if (!resume_done) begin
                wake_cnt <= wake_cnt + RES_W'(1);
            end
        end
    end

    // ---------------- Registers ----------------
    logic five_rx;
    logic tx_en;

    // ---------------- Output stage ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            charge_pump_en <= 1'b0;
            tx_out <= '0;
            tx_oe_n <= '1;
            rx_data_out <= '0;
            rx_oe_n <= '1;
            wake_monitor_out <= 1'b0;
            ready_out <= 1'b0;
            tx_en <= 1'b0;
        end else if (clk_en) begin
            charge_pump_en <= next_on;
            tx_en <= next_tx_en;
            tx_out <= ~tx_clean;
            tx_oe_n <= {N_TX{~next_tx_en}};
            rx_data_out <= ~rx_clean;
            rx_oe_n <= {N_RX{five_rx && (next_state == SPD_MAN_OFF)}};
            wake_monitor_out <= rx_clean[MON_RX_IDX];
            ready_out <= next_on && supply_ok;
        end
    end

    // Flag lines disable, cable schemes rely on this
    spd_level_detect u_level (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .any_valid(any_valid),
        .level_ok(level_ok_out)
    );

    // ---------------- AXI4-Lite slave ----------------
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic wr_ctrl;
    logic ar_take;
    logic [31:0] status_word;
    logic [31:0] rd_word;

    assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_have & w_have & ~s_axi_bvalid;
    assign wr_ctrl = do_write && (aw_addr == REG_CTRL) &&
        w_strb[0];
    assign ar_take = s_axi_arvalid & s_axi_arready;

    always_comb begin
        status_word = '0;
        status_word[STAT_ON_BIT] = (state == SPD_ON);
        status_word[STAT_AUTO_BIT] = (state == SPD_AUTO_OFF);
        status_word[STAT_MAN_BIT] = (state == SPD_MAN_OFF);
        status_word[STAT_EXP_BIT] = expired;
        status_word[STAT_LVL_BIT] = level_ok_out;
        status_word[STAT_RDY_BIT] = ready_out;
        status_word[STAT_TXEN_BIT] = tx_en;
    end

    assign rd_word = (s_axi_araddr == REG_CTRL) ? {31'h0, five_rx} :
        (s_axi_araddr == REG_STATUS) ? status_word :
        (s_axi_araddr == REG_IDLE) ? idle_cnt : 32'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= reg_mapped(aw_addr) ? RESP_OKAY :
                    RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Receiver disable in manual powerdown applies only when set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            five_rx <= CTRL_FIVE_RX_RESET;
        end else if (clk_en && wr_ctrl) begin
            five_rx <= w_data[CTRL_FIVE_RX_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= reg_mapped(s_axi_araddr) ? RESP_OKAY :
                    RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // spd_powerdown_ctrl

`default_nettype wire

// ===== spd_powerdown_ctrl_props.sv
// Port assertions for the powerdown control
`timescale 1ns/1ps
`default_nettype none
module spd_powerdown_ctrl_props
    import spd_pkg::*;
#(
    parameter logic [IDLE_W-1:0] IDLE_CYC = IDLE_CYC_DEF,
    parameter logic [RES_W-1:0] RESUME_CYC = RESUME_CYC_DEF
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hold_awake_in,
    input wire logic shutdown_req_n,
    input wire logic [N_TX-1:0] tx_data_in,
    input wire logic [N_RX-1:0] rx_data_in,
    input wire logic [N_RX-1:0] rx_level_valid,
    input wire logic charge_pump_en,
    input wire logic [N_TX-1:0] tx_oe_n,
    input wire logic level_ok_out
);
    localparam int RES_LIM = int'(RESUME_CYC) + 8;
    localparam logic [31:0] IDLE_LIM = 32'(IDLE_CYC) + 32'h0000000a;
    logic [11:0] lvl_cnt;
    logic lvl_prev;
    logic [31:0] idle_cnt;
    logic [N_TX-1:0] tx_prev;
    logic [N_RX-1:0] rx_prev;
    wire logic any_valid = |rx_level_valid;
    wire logic edge_seen = (tx_data_in != tx_prev) || (rx_data_in != rx_prev);
    wire logic idle_now = !hold_awake_in && shutdown_req_n && !edge_seen;
    // Cycles since the level input last changed, saturating
    wire logic [11:0] next_lvl_cnt = (any_valid != lvl_prev) ? 12'h000 :
        lvl_cnt + 12'(lvl_cnt != 12'hfff);
    wire logic [31:0] next_idle_cnt = idle_now ?
        idle_cnt + 32'(idle_cnt != '1) : 32'h0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {lvl_cnt, lvl_prev, idle_cnt, tx_prev, rx_prev} <= '0;
        end else begin
            {lvl_cnt, lvl_prev, idle_cnt} <=
                {next_lvl_cnt, any_valid, next_idle_cnt};
            {tx_prev, rx_prev} <= {tx_data_in, rx_data_in};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_off_tristate: assert property (
        !charge_pump_en |-> tx_oe_n == '1)
        else $error("transmitters driving with pump off");
    a_request_forces_off: assert property (
        (!shutdown_req_n) [*6] |-> !charge_pump_en)
        else $error("pump on during shutdown request");
    a_both_high_on: assert property (
        (hold_awake_in && shutdown_req_n) [*8] |-> charge_pump_en)
        else $error("pump off with both controls high");
    a_tx_resume: assert property (
        $rose(charge_pump_en) |->
            ##[0:RES_LIM] (!charge_pump_en || tx_oe_n == '0))
        else $error("transmitters not resumed in time");
    a_flag_low_late: assert property (
        (!any_valid && lvl_cnt == 12'hbc7) |-> !level_ok_out)
        else $error("flag still high after invalid period");
    a_flag_fall_early: assert property (
        $fell(level_ok_out) |-> !any_valid && lvl_cnt >= 12'hbb8)
        else $error("flag fell too early");
    a_flag_rise: assert property (
        (any_valid && lvl_cnt == 12'h06e) |-> level_ok_out)
        else $error("flag not high after valid level");
    a_idle_down: assert property (
        idle_cnt == IDLE_LIM |-> !charge_pump_en)
        else $error("no powerdown after inactivity");
    a_edge_wakes: assert property (
        (shutdown_req_n && !charge_pump_en && edge_seen) |->
            ##[1:10] charge_pump_en)
        else $error("input edge did not wake");
endmodule // spd_powerdown_ctrl_props

bind spd_powerdown_ctrl spd_powerdown_ctrl_props #(.IDLE_CYC(IDLE_CYC),
    .RESUME_CYC(RESUME_CYC)) spd_powerdown_ctrl_props_inst (.ref_clk, .rst,
    .hold_awake_in, .shutdown_req_n, .tx_data_in, .rx_data_in,
    .rx_level_valid, .charge_pump_en, .tx_oe_n, .level_ok_out);
`default_nettype wire

// ===== spd_line_partner.sv
// Line side model: supply ramp and cabled peripheral
`timescale 1ns/1ps
`default_nettype none
module spd_line_partner
    import spd_pkg::*;
#(
    parameter int SUP_DLY = 12
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic charge_pump_en,
    input wire logic cable_on,
    input wire logic toggle,
    output var logic neg_supply_ok,
    output var logic [N_RX-1:0] rx_data_in,
    output var logic [N_RX-1:0] rx_level_valid
);
    int ramp;
    logic [N_RX-1:0] line;
    // Detached inputs fall to the pull-down level
    assign rx_level_valid = cable_on ? '1 : '0;
    assign rx_data_in = cable_on ? line : '0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ramp <= 0;
            line <= '0;
            neg_supply_ok <= 1'h0;
        end else begin
            ramp <= charge_pump_en ? ramp + int'(ramp < SUP_DLY) : 0;
            neg_supply_ok <= charge_pump_en && ramp >= SUP_DLY;
            if (toggle) line <= ~line;
        end
    end
endmodule // spd_line_partner
`default_nettype wire

// ===== serial_transceiver_powerdown_ctrl_bench.sv
// Self-checking bench for the powerdown control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    miscompares++; $display("unexpected at %0t: %h not %h", $time, a, b); \
    end end
module serial_transceiver_powerdown_ctrl_bench
    import spd_pkg::*;
;
    typedef struct packed {
        logic hold, sd, pump;
        logic [2:0] txoe;
        logic [4:0] rxoe;
        logic rdy;
    } spd_row_t;
    spd_row_t rows [6] = '{
        '{1'h1, 1'h1, 1'h1, 3'h0, 5'h00, 1'h1},
        '{1'h1, 1'h0, 1'h0, 3'h7, 5'h1f, 1'h0},
        '{1'h0, 1'h0, 1'h0, 3'h7, 5'h1f, 1'h0},
        '{1'h0, 1'h1, 1'h0, 3'h7, 5'h00, 1'h0},
        '{1'h1, 1'h1, 1'h1, 3'h0, 5'h00, 1'h1},
        '{1'h0, 1'h1, 1'h1, 3'h0, 5'h00, 1'h1}};
    int miscompares = 0;
    int samples_checked = 0;
    logic ref_clk = 1'h0, rst = 1'h1, hold_awake_in = 1'h0, toggle = 1'h0;
    logic shutdown_req_n = 1'h1, cable_on = 1'h1, clk_en = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, data;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, neg_supply_ok, charge_pump_en, wake_monitor_out;
    logic level_ok_out, ready_out;
    logic [N_TX-1:0] tx_data_in = '0, tx_out, tx_oe_n;
    logic [N_RX-1:0] rx_data_in, rx_level_valid, rx_data_out, rx_oe_n;
    spd_powerdown_ctrl #(.IDLE_CYC(32'h000000c8), .RESUME_CYC(16'h0032))
    spd_powerdown_ctrl_inst (.ref_clk, .rst, .clk_en, .hold_awake_in,
        .shutdown_req_n, .tx_data_in, .rx_data_in, .rx_level_valid,
        .neg_supply_ok, .charge_pump_en, .tx_out, .tx_oe_n, .rx_data_out,
        .rx_oe_n, .wake_monitor_out, .level_ok_out, .ready_out,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    spd_line_partner spd_line_partner_inst (.ref_clk, .rst, .charge_pump_en,
        .cable_on, .toggle, .neg_supply_ok, .rx_data_in, .rx_level_valid);
    task automatic end_sim();
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic hang(input int n);
        if (n > 100) begin
            $display("unexpected at %0t: no bus answer", $time);
            miscompares++;
            end_sim();
        end
    endtask
    task automatic pins(input logic h, input logic s);
        @(posedge ref_clk);
        hold_awake_in <= h;
        shutdown_req_n <= s;
    endtask
    task automatic tog();
        @(posedge ref_clk);
        toggle <= 1'h1;
        @(posedge ref_clk);
        toggle <= 1'h0;
    endtask
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
            hang(n);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_read(input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
            hang(n);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        $display("unexpected at %0t: run too long", $time);
        miscompares++;
        end_sim();
    end
    initial begin
        wait_cyc(2);
        `CHK(charge_pump_en, 1'h0)
        `CHK(tx_oe_n, 3'h7)
        `CHK(s_axi_awready, 1'h1)
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        $display("reset test done");
        // Mode table: all four hold and request combinations
        for (int i = 0; i < 6; i++) begin
            pins(rows[i].hold, rows[i].sd);
            wait_cyc(30);
            `CHK(charge_pump_en, rows[i].pump)
            `CHK(tx_oe_n, rows[i].txoe)
            `CHK(rx_oe_n, rows[i].rxoe)
            `CHK(ready_out, rows[i].rdy)
        end
        $display("mode table done");
        wait_cyc(130);
        `CHK(charge_pump_en, 1'h1)
        wait_cyc(60);
        `CHK(charge_pump_en, 1'h0)
        `CHK(ready_out, 1'h0)
        @(posedge ref_clk);
        tx_data_in <= 3'h5;
        wait_cyc(30);
        `CHK(charge_pump_en, 1'h1)
        `CHK({tx_out, tx_oe_n}, 6'h10)
        $display("auto powerdown done");
        pins(1'h0, 1'h0);
        tog();
        wait_cyc(20);
        `CHK(charge_pump_en, 1'h0)
        `CHK(wake_monitor_out, rx_data_in[0])
        `CHK(rx_data_out, 5'h00)
        pins(1'h0, 1'h1);
        wait_cyc(20);
        `CHK(charge_pump_en, 1'h0)
        tog();
        wait_cyc(15);
        `CHK(charge_pump_en, 1'h1)
        $display("manual powerdown done");
        axi_read(REG_CTRL);
        `CHK({resp, data}, {RESP_OKAY, 32'h00000001})
        axi_write(REG_CTRL, 32'h0);
        `CHK(resp, RESP_OKAY)
        pins(1'h0, 1'h0);
        wait_cyc(20);
        `CHK(rx_oe_n, 5'h00)
        axi_read(REG_STATUS);
        `CHK(data[STAT_MAN_BIT], 1'h1)
        axi_read(8'h0c);
        `CHK({resp, data}, {RESP_SLVERR, 32'h0})
        axi_write(8'h0c, 32'h1);
        `CHK(resp, RESP_SLVERR)
        $display("register test done");
        pins(1'h1, 1'h1);
        cable_on <= 1'h0;
        wait_cyc(2990);
        `CHK(level_ok_out, 1'h1)
        wait_cyc(40);
        `CHK({level_ok_out, charge_pump_en}, 2'h1)
        @(posedge ref_clk);
        cable_on <= 1'h1;
        wait_cyc(95);
        `CHK(level_ok_out, 1'h0)
        wait_cyc(20);
        `CHK(level_ok_out, 1'h1)
        $display("level flag done");
        // Frozen enable holds the outputs
        @(posedge ref_clk);
        clk_en <= 1'h0;
        tx_data_in <= 3'h2;
        wait_cyc(10);
        `CHK(tx_out, 3'h2)
        @(posedge ref_clk);
        clk_en <= 1'h1;
        wait_cyc(10);
        `CHK(tx_out, 3'h5)
        $display("clock enable test done");
        // Hybrid: flag drives the request, hold low
        pins(1'h0, level_ok_out);
        cable_on <= 1'h0;
        wait_cyc(3010);
        pins(1'h0, level_ok_out);
        wait_cyc(20);
        axi_read(REG_STATUS);
        `CHK(data[STAT_MAN_BIT], 1'h1)
        pins(1'h0, level_ok_out);
        cable_on <= 1'h1;
        wait_cyc(110);
        pins(1'h0, level_ok_out);
        wait_cyc(20);
        `CHK(charge_pump_en, 1'h0)
        tog();
        wait_cyc(15);
        `CHK(charge_pump_en, 1'h1)
        // Flag drives both controls
        pins(level_ok_out, level_ok_out);
        cable_on <= 1'h0;
        wait_cyc(3010);
        pins(level_ok_out, level_ok_out);
        wait_cyc(20);
        `CHK(charge_pump_en, 1'h0)
        pins(level_ok_out, level_ok_out);
        cable_on <= 1'h1;
        wait_cyc(110);
        pins(level_ok_out, level_ok_out);
        wait_cyc(20);
        `CHK(charge_pump_en, 1'h1)
        $display("cable schemes done");
        @(posedge ref_clk);
        rst <= 1'h1;
        wait_cyc(3);
        `CHK({charge_pump_en, ready_out}, 2'h0)
        @(posedge ref_clk);
        rst <= 1'h0;
        $display("second reset done");
        end_sim();
    end
endmodule // serial_transceiver_powerdown_ctrl_bench
`default_nettype wire
